// *** sdram_cmd_pkg.sv ***
// Overview of operation
// [RQ1] Commands, addresses, masks and write data are taken on the rising clock edge.
// [RQ2] Clock hold sampled low suspends the inner clock from the next cycle onward.
// [RQ3] Clock hold low with all banks idle enters power down or self refresh.
// [RQ4] The two bank pick pins choose the bank of each bank command.
// [RQ5] Activate latches a 13-bit row; read or write a 9-bit column, bit 10 auto close.
// [RQ6] Precharge with bit 10 high closes all banks, low only the picked bank.
// [RQ7] Mode set is all strobes low, taken only with all banks idle.
// [RQ8] Chip select high masks every command as a deselect.
// [RQ9] Row strobe low, column high: write high activates, write low precharges.
// [RQ10] Row high, column low: write low writes, high reads; stop on write alone.
// [RQ11] Each byte mask governs exactly one byte lane of the data bus.
// [RQ12] Mask drops write data at once and blanks read data two clocks later.
// [RQ13] Commands are qualified by prior and present clock hold levels.
// [RQ14] Clock hold falling during a burst gives clock suspend, not power down.
// [RQ15] Read latency is programmable as two or three clocks.
// [RQ16] Bursts of 1, 2, 4, 8 or a full page, linear or interleaved.
// [RQ17] Activate opens a row in an idle bank before any access to it.
// [RQ18] Controller precharges before a new row and spaces same-bank activates.
// [RQ19] Controller spaces activates to different banks by the bank gap.
// [RQ20] Each bank holds 8192 rows of 512 columns of 32-bit words.
// [RQ21] Controller precharges every active bank before the active time runs out.
// [RQ22] Controller fills waiting cycles with no-operation or deselect.
// [RQ23] Controller issues enough auto refresh to cover all rows each period.
`default_nettype none

package sdram_cmd_pkg;

  // ==========================================================
  // Geometry
  localparam int BANKS  = 4;
  localparam int ROWS   = 8192;
  localparam int COLS   = 512;
  localparam int BANK_W = $clog2(BANKS);
  localparam int ROW_W  = $clog2(ROWS);
  localparam int COL_W  = $clog2(COLS);
  localparam int DATA_W = 32;
  localparam int LANES  = DATA_W / 8;
  localparam int BEAT_W = COL_W + 1;

  // ==========================================================
  // Address and mode fields
  localparam int AP_BIT = 10;
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam logic [ROW_W-1:0]  MODE_RESET = 13'h0020;
  localparam logic [2:0]        CL_THREE   = 3'h3;
  localparam logic [BEAT_W-1:0] FULL_PAGE  = 10'h200;

  // ==========================================================
  // Commands and modes
  typedef enum logic [3:0] {
    CMD_DESELECT   = 4'h0,
    CMD_NOP        = 4'h1,
    CMD_ACTIVATE   = 4'h2,
    CMD_PRECHARGE  = 4'h3,
    CMD_READ       = 4'h4,
    CMD_WRITE      = 4'h5,
    CMD_MODE_SET   = 4'h6,
    CMD_REFRESH    = 4'h7,
    CMD_BURST_STOP = 4'h8
  } cmd_t;

  typedef enum logic [1:0] {
    ST_RUN          = 2'h0,
    ST_SUSPEND      = 2'h1,
    ST_POWER_DOWN   = 2'h2,
    ST_SELF_REFRESH = 2'h3
  } mode_state_t;

  // ==========================================================
  // Decoding
  function automatic cmd_t decode_cmd(input logic cs_n, input logic [2:0] strobes);
    cmd_t c;
    c = CMD_DESELECT;
    if (!cs_n) begin
      case (strobes)
        3'h3:    c = CMD_ACTIVATE;
        3'h2:    c = CMD_PRECHARGE;
        3'h5:    c = CMD_READ;
        3'h4:    c = CMD_WRITE;
        3'h0:    c = CMD_MODE_SET;
        3'h1:    c = CMD_REFRESH;
        3'h6:    c = CMD_BURST_STOP;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [BEAT_W-1:0] burst_len(input logic [2:0] code);
    case (code)
      3'h0:    return 10'h001;
      3'h1:    return 10'h002;
      3'h2:    return 10'h004;
      3'h3:    return 10'h008;
      3'h7:    return FULL_PAGE;
      default: return 10'h001;
    endcase
  endfunction

  // Column of a beat; interleave only applies to bursts up to eight
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0]  start,
                                                 input logic [BEAT_W-1:0] cnt,
                                                 input logic [BEAT_W-1:0] len,
                                                 input logic              ilv);
    logic [COL_W-1:0] wrap;
    wrap = COL_W'(len - 10'h001);
    if (ilv && len <= 10'h008)
      return (start & ~wrap) | ((start ^ cnt[COL_W-1:0]) & wrap);
    return (start & ~wrap) | (COL_W'(start + cnt[COL_W-1:0]) & wrap);
  endfunction

endpackage

`default_nettype wire

// *** bank_if.sv ***
`default_nettype none

// ==========================================================
// Bank open and close requests with bank state
interface bank_if;
  logic                                act;
  logic                                pre;
  logic                                pre_all;
  logic [sdram_cmd_pkg::BANK_W-1:0]    bank;
  logic [sdram_cmd_pkg::ROW_W-1:0]     row;
  logic                                ap_close;
  logic [sdram_cmd_pkg::BANK_W-1:0]    ap_bank;
  logic [sdram_cmd_pkg::BANKS-1:0]     open;
  logic [sdram_cmd_pkg::ROW_W-1:0]     rows [sdram_cmd_pkg::BANKS];

  modport tracker (input act, pre, pre_all, bank, row, ap_close, ap_bank,
                   output open, rows);
  modport user    (output act, pre, pre_all, bank, row, ap_close, ap_bank,
                   input open, rows);
endinterface

`default_nettype wire

// *** bank_tracker.sv ***
`default_nettype none

module bank_tracker (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Bank requests
  bank_if.tracker   bus
);

  logic [sdram_cmd_pkg::BANKS-1:0] next_open;

  // ==========================================================
  // Open flags; an activate wins over an auto close in one cycle
  always_comb begin
    next_open = bus.open;
    if (bus.ap_close) begin
      next_open[bus.ap_bank] = 1'b0;
    end
    if (bus.pre && bus.pre_all) begin
      next_open = '0; // [RQ6]
    end else if (bus.pre) begin
      next_open[bus.bank] = 1'b0; // [RQ4] [RQ9]
    end
    if (bus.act) begin
      next_open[bus.bank] = 1'b1; // [RQ17]
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus.open <= '0;
    end else if (clk_en) begin
      bus.open <= next_open;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < sdram_cmd_pkg::BANKS; i++) begin
        bus.rows[i] <= '0;
      end
    end else if (clk_en && bus.act) begin
      bus.rows[bus.bank] <= bus.row; // [RQ5] [RQ20]
    end
  end

  property p_row_open;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && bus.act) |=> bus.open[$past(bus.bank)] &&
                            bus.rows[$past(bus.bank)] == $past(bus.row);
  endproperty
  a_row_open: assert property (p_row_open) else $error("row not opened"); // [RQ17]

endmodule

`default_nettype wire

// *** sdram_command_interface.sv ***
`default_nettype none

module sdram_command_interface (
  // Clock, reset, enable
  input  wire logic                                ref_clk,
  input  wire logic                                reset,
  input  wire logic                                clk_en,
  // Command pins
  input  wire logic                                chip_sel_n,
  input  wire logic                                row_strobe_n,
  input  wire logic                                col_strobe_n,
  input  wire logic                                write_strobe_n,
  input  wire logic                                clock_hold,
  input  wire logic [sdram_cmd_pkg::BANK_W-1:0]    bank_pick_pins,
  input  wire logic [sdram_cmd_pkg::ROW_W-1:0]     addr,
  input  wire logic [sdram_cmd_pkg::LANES-1:0]     byte_lane_mask,
  // Data pins
  input  wire logic [sdram_cmd_pkg::DATA_W-1:0]    data_lines_in,
  output logic      [sdram_cmd_pkg::DATA_W-1:0]    data_lines_out,
  output logic      [sdram_cmd_pkg::LANES-1:0]     data_lines_oe,
  // Array port
  output logic                                     mem_wr,
  output logic                                     mem_rd,
  output logic      [sdram_cmd_pkg::BANK_W-1:0]    mem_bank,
  output logic      [sdram_cmd_pkg::ROW_W-1:0]     mem_row,
  output logic      [sdram_cmd_pkg::COL_W-1:0]     mem_col,
  output logic      [sdram_cmd_pkg::DATA_W-1:0]    mem_wdata,
  output logic      [sdram_cmd_pkg::LANES-1:0]     mem_byte_en,
  input  wire logic [sdram_cmd_pkg::DATA_W-1:0]    mem_rdata,
  // Status
  output logic      [sdram_cmd_pkg::ROW_W-1:0]     mode_opcode,
  output logic      [sdram_cmd_pkg::BANKS-1:0]     bank_open,
  output logic                                     power_down,
  output logic                                     self_refresh,
  output logic                                     clock_suspend,
  output logic                                     refresh_pulse,
  output logic                                     cmd_refused
);

  // ==========================================================
  // Declarations
  sdram_cmd_pkg::cmd_t        cmd;
  sdram_cmd_pkg::mode_state_t state;
  sdram_cmd_pkg::mode_state_t next_state;

  logic                                run;
  logic                                cke_q;
  logic                                cke_meta;
  logic                                cke_sync;
  logic                                all_idle;
  logic                                target_open;
  logic                                col_cmd;
  logic                                stop_burst;
  logic                                burst_done;
  logic                                cl3;
  logic                                refuse;

  logic                                burst_active;
  logic                                burst_write;
  logic                                burst_ap;
  logic                                burst_ilv;
  logic [sdram_cmd_pkg::BANK_W-1:0]    burst_bank;
  logic [sdram_cmd_pkg::COL_W-1:0]     burst_start;
  logic [sdram_cmd_pkg::BEAT_W-1:0]    burst_cnt;
  logic [sdram_cmd_pkg::BEAT_W-1:0]    burst_len_q;

  logic [1:0]                          rd_pipe;
  logic [sdram_cmd_pkg::DATA_W-1:0]    rd_hold;
  logic [sdram_cmd_pkg::LANES-1:0]     mask_d1;
  logic [sdram_cmd_pkg::LANES-1:0]     mask_d2;

  bank_if banks ();

  bank_tracker u_tracker (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .bus     (banks)
  );

  // ==========================================================
  // Command decode
  // Inner clock runs only while the prior hold level was high
  assign run = clk_en && cke_q && (state == sdram_cmd_pkg::ST_RUN); // [RQ2] [RQ13]

  assign cmd = sdram_cmd_pkg::decode_cmd(chip_sel_n, // [RQ8]
                 {row_strobe_n, col_strobe_n, write_strobe_n}); // [RQ9] [RQ10]

  assign all_idle    = (banks.open == '0);
  assign target_open = banks.open[bank_pick_pins]; // [RQ4]
  assign bank_open   = banks.open;

  assign col_cmd = run && target_open && // [RQ17]
                   (cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE);

  assign stop_burst = run && (cmd == sdram_cmd_pkg::CMD_BURST_STOP || // [RQ10]
                      (cmd == sdram_cmd_pkg::CMD_PRECHARGE &&
                       (addr[sdram_cmd_pkg::AP_BIT] || bank_pick_pins == burst_bank)));

  // Full page bursts wrap until stopped
  assign burst_done = burst_active && (burst_cnt == burst_len_q) &&
                      (burst_len_q != sdram_cmd_pkg::FULL_PAGE); // [RQ16]

  assign cl3 = (mode_opcode[sdram_cmd_pkg::CL_LSB +: 3] == sdram_cmd_pkg::CL_THREE);

  // Illegal-state commands are dropped, never half executed
  assign refuse = run &&
    ((cmd == sdram_cmd_pkg::CMD_ACTIVATE && target_open) ||
     ((cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE) && !target_open) ||
     ((cmd == sdram_cmd_pkg::CMD_MODE_SET || cmd == sdram_cmd_pkg::CMD_REFRESH) &&
      (!all_idle || burst_active)));

  always_comb begin
    banks.act      = run && cmd == sdram_cmd_pkg::CMD_ACTIVATE && !target_open; // [RQ9]
    banks.pre      = run && cmd == sdram_cmd_pkg::CMD_PRECHARGE; // [RQ9]
    banks.pre_all  = addr[sdram_cmd_pkg::AP_BIT]; // [RQ6]
    banks.bank     = bank_pick_pins; // [RQ4]
    banks.row      = addr; // [RQ5]
    banks.ap_close = run && burst_done && burst_ap; // [RQ5]
    banks.ap_bank  = burst_bank;
  end

  // ==========================================================
  // Clock hold sampling
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cke_q <= 1'b1;
    end else if (clk_en) begin
      cke_q <= clock_hold; // [RQ13]
    end
  end

  // Async exit path; second stage held low while running, so no stale high ends power down
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cke_meta <= 1'b1;
      cke_sync <= 1'b1;
    end else if (clk_en) begin
      cke_meta <= clock_hold;
      cke_sync <= cke_meta && (state != sdram_cmd_pkg::ST_RUN); // [RQ3]
    end
  end

  // ==========================================================
  // Power mode state
  always_comb begin
    next_state = state;
    case (state)
      sdram_cmd_pkg::ST_RUN: begin
        if (cke_q && !clock_hold) begin
          if (burst_active && !burst_done) begin
            next_state = sdram_cmd_pkg::ST_SUSPEND; // [RQ14]
          end else if (cmd == sdram_cmd_pkg::CMD_REFRESH && all_idle) begin
            next_state = sdram_cmd_pkg::ST_SELF_REFRESH; // [RQ13]
          end else if (all_idle && (cmd == sdram_cmd_pkg::CMD_NOP ||
                                    cmd == sdram_cmd_pkg::CMD_DESELECT)) begin
            next_state = sdram_cmd_pkg::ST_POWER_DOWN; // [RQ3]
          end else begin
            next_state = sdram_cmd_pkg::ST_SUSPEND; // [RQ2]
          end
        end
      end
      sdram_cmd_pkg::ST_SUSPEND: begin
        if (clock_hold) begin
          next_state = sdram_cmd_pkg::ST_RUN;
        end
      end
      sdram_cmd_pkg::ST_POWER_DOWN, sdram_cmd_pkg::ST_SELF_REFRESH: begin
        if (cke_sync) begin
          next_state = sdram_cmd_pkg::ST_RUN; // [RQ3]
        end
      end
      default: next_state = sdram_cmd_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= sdram_cmd_pkg::ST_RUN;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign power_down    = (state == sdram_cmd_pkg::ST_POWER_DOWN);
  assign self_refresh  = (state == sdram_cmd_pkg::ST_SELF_REFRESH);
  assign clock_suspend = (state == sdram_cmd_pkg::ST_SUSPEND);

  // ==========================================================
  // Mode register, refresh and refusal
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_opcode <= sdram_cmd_pkg::MODE_RESET;
    end else if (run && cmd == sdram_cmd_pkg::CMD_MODE_SET && all_idle && !burst_active) begin
      mode_opcode <= addr; // [RQ7]
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      refresh_pulse <= 1'b0;
      cmd_refused   <= 1'b0;
    end else if (clk_en) begin
      refresh_pulse <= run && cmd == sdram_cmd_pkg::CMD_REFRESH && clock_hold &&
                       all_idle && !burst_active; // [RQ13]
      cmd_refused   <= refuse;
    end
  end

  // ==========================================================
  // Burst counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
      burst_ap     <= 1'b0;
      burst_ilv    <= 1'b0;
      burst_bank   <= '0;
      burst_start  <= '0;
      burst_cnt    <= '0;
      burst_len_q  <= '0;
    end else if (run) begin // [RQ1]
      if (col_cmd) begin
        burst_active <= 1'b1;
        burst_write  <= (cmd == sdram_cmd_pkg::CMD_WRITE);
        burst_ap     <= addr[sdram_cmd_pkg::AP_BIT]; // [RQ5]
        burst_bank   <= bank_pick_pins;
        burst_start  <= addr[sdram_cmd_pkg::COL_W-1:0];
        burst_cnt    <= 10'h001;
        burst_len_q  <= sdram_cmd_pkg::burst_len(mode_opcode[sdram_cmd_pkg::BL_LSB +: 3]);
        burst_ilv    <= mode_opcode[sdram_cmd_pkg::BT_BIT]; // [RQ16]
      end else if (stop_burst || burst_done) begin
        burst_active <= 1'b0;
      end else if (burst_active) begin
        burst_cnt <= burst_cnt + 10'h001;
      end
    end
  end

  // ==========================================================
  // Array port; one beat per running cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_wr      <= 1'b0;
      mem_rd      <= 1'b0;
      mem_bank    <= '0;
      mem_row     <= '0;
      mem_col     <= '0;
      mem_wdata   <= '0;
      mem_byte_en <= '0;
    end else if (clk_en) begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      if (col_cmd) begin
        mem_wr      <= (cmd == sdram_cmd_pkg::CMD_WRITE); // [RQ10]
        mem_rd      <= (cmd == sdram_cmd_pkg::CMD_READ);
        mem_bank    <= bank_pick_pins; // [RQ4]
        mem_row     <= banks.rows[bank_pick_pins];
        mem_col     <= addr[sdram_cmd_pkg::COL_W-1:0]; // [RQ5]
        mem_wdata   <= data_lines_in; // [RQ1]
        mem_byte_en <= ~byte_lane_mask; // [RQ11] [RQ12]
      end else if (run && burst_active && !burst_done && !stop_burst) begin
        mem_wr      <= burst_write;
        mem_rd      <= !burst_write;
        mem_col     <= sdram_cmd_pkg::burst_col(burst_start, burst_cnt,
                                                burst_len_q, burst_ilv); // [RQ16]
        mem_wdata   <= data_lines_in;
        mem_byte_en <= ~byte_lane_mask; // [RQ11] [RQ12]
      end
    end
  end

  // ==========================================================
  // Read return; frozen together with the inner clock
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_pipe        <= '0;
      rd_hold        <= '0;
      mask_d1        <= '0;
      mask_d2        <= '0;
      data_lines_out <= '0;
      data_lines_oe  <= '0;
    end else if (run) begin // [RQ2]
      rd_pipe        <= {rd_pipe[0], mem_rd};
      rd_hold        <= mem_rdata;
      mask_d1        <= byte_lane_mask;
      mask_d2        <= mask_d1; // [RQ12]
      data_lines_out <= cl3 ? rd_hold : mem_rdata; // [RQ15]
      data_lines_oe  <= {sdram_cmd_pkg::LANES{cl3 ? rd_pipe[1] : rd_pipe[0]}} &
                        ~mask_d2; // [RQ11] [RQ12]
    end
  end

  // ==========================================================
  // Checks
  property p_deselect;
    @(posedge ref_clk) disable iff (reset)
    (run && chip_sel_n && !burst_active) |=> !mem_wr && !mem_rd;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect acted"); // [RQ8]

  property p_activate;
    @(posedge ref_clk) disable iff (reset)
    (run && cmd == sdram_cmd_pkg::CMD_ACTIVATE && !target_open)
      |=> bank_open[$past(bank_pick_pins)];
  endproperty
  a_activate: assert property (p_activate) else $error("bank not opened"); // [RQ9]

  property p_pre_all;
    @(posedge ref_clk) disable iff (reset)
    (run && cmd == sdram_cmd_pkg::CMD_PRECHARGE && addr[sdram_cmd_pkg::AP_BIT])
      |=> bank_open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("banks left open"); // [RQ6]

  property p_col_latch;
    @(posedge ref_clk) disable iff (reset)
    (col_cmd && cmd == sdram_cmd_pkg::CMD_READ)
      |=> mem_rd && mem_col == $past(addr[sdram_cmd_pkg::COL_W-1:0]);
  endproperty
  a_col_latch: assert property (p_col_latch) else $error("column not latched"); // [RQ5]

  property p_wr_mask;
    @(posedge ref_clk) disable iff (reset)
    (col_cmd && cmd == sdram_cmd_pkg::CMD_WRITE)
      |=> mem_wr && mem_byte_en == ~$past(byte_lane_mask);
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("write mask wrong"); // [RQ12]

  property p_rd_mask;
    @(posedge ref_clk) disable iff (reset)
    (run && byte_lane_mask[0]) ##1 run ##1 run |=> !data_lines_oe[0];
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("masked lane driven"); // [RQ12]

  property p_cas_two;
    @(posedge ref_clk) disable iff (reset)
    (col_cmd && cmd == sdram_cmd_pkg::CMD_READ && !cl3 && byte_lane_mask == '0)
      ##1 run ##1 run |=> data_lines_oe == '1;
  endproperty
  a_cas_two: assert property (p_cas_two) else $error("read latency wrong"); // [RQ15]

  property p_freeze;
    @(posedge ref_clk) disable iff (reset)
    clock_suspend |=> $stable(data_lines_out) && $stable(burst_cnt);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved in suspend"); // [RQ2]

  property p_burst_suspend;
    @(posedge ref_clk) disable iff (reset)
    (run && !clock_hold && burst_active && !burst_done) |=> clock_suspend;
  endproperty
  a_burst_suspend: assert property (p_burst_suspend) else $error("no suspend"); // [RQ14]

  property p_self_ref;
    @(posedge ref_clk) disable iff (reset)
    (run && cmd == sdram_cmd_pkg::CMD_REFRESH && !clock_hold && all_idle &&
     !burst_active) |=> self_refresh && !refresh_pulse;
  endproperty
  a_self_ref: assert property (p_self_ref) else $error("self refresh missed"); // [RQ13]

  property p_mode_set;
    @(posedge ref_clk) disable iff (reset)
    (run && cmd == sdram_cmd_pkg::CMD_MODE_SET && all_idle && !burst_active)
      |=> mode_opcode == $past(addr);
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode not taken"); // [RQ7]

  property p_pd_exit;
    @(posedge ref_clk) disable iff (reset)
    (power_down && clock_hold && clk_en) ##1 clk_en ##1 clk_en |=> !power_down;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power down stuck"); // [RQ3]

endmodule

`default_nettype wire

// *** array_model.sv ***
`default_nettype none

// ==========================================================
// Cell array behind the block, one-cycle registered read
module array_model (
  // Clock
  input  wire logic        ref_clk,
  // Array port
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [8:0]  mem_col,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [3:0]  mem_byte_en,
  output logic      [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cells [512];
  // Bank and row ignored to stay small; idle output toggles
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (mem_wr && mem_byte_en[i]) cells[mem_col][8*i +: 8] <= mem_wdata[8*i +: 8];
    end
    mem_rdata <= mem_rd ? cells[mem_col] : ~mem_rdata;
  end
endmodule

`default_nettype wire

// *** tb.sv ***
`default_nettype none

// ==========================================================
// Bench
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0]  cmd;
    logic [1:0]  bank;
    logic [12:0] addr;
    logic [3:0]  open;
    logic        refused;
  } row_t;
  logic        ref_clk, reset, cs_n, ras_n, cas_n, we_n, hold, wr, rd, pd, refused, rfp, susp;
  logic [1:0]  bank;
  logic [12:0] addr, opcode;
  logic [3:0]  mask, oe, open, ben;
  logic [8:0]  col;
  logic [31:0] din, dout, rdata, wdata;
  int          bad_count, checked;
  // Deselect, activate, two-clock read, refusals, precharge one, precharge all, mode set
  row_t rows [11] = '{'{4'h8, 2'h0, 13'h0000, 4'h0, 1'b0}, '{4'h3, 2'h1, 13'h1abc, 4'h2, 1'b0},
    '{4'h3, 2'h1, 13'h0001, 4'h2, 1'b1}, '{4'h5, 2'h1, 13'h0000, 4'h2, 1'b0},
    '{4'h5, 2'h0, 13'h0000, 4'h2, 1'b1},
    '{4'h0, 2'h0, 13'h0032, 4'h2, 1'b1}, '{4'h3, 2'h3, 13'h0000, 4'ha, 1'b0},
    '{4'h2, 2'h1, 13'h0000, 4'h8, 1'b0}, '{4'h3, 2'h0, 13'h0000, 4'h9, 1'b0},
    '{4'h2, 2'h2, 13'h0400, 4'h0, 1'b0}, '{4'h0, 2'h0, 13'h0032, 4'h0, 1'b0}};

  sdram_command_interface dut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .chip_sel_n(cs_n), .row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_strobe_n(we_n),
    .clock_hold(hold), .bank_pick_pins(bank), .addr(addr), .byte_lane_mask(mask),
    .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(oe), .mem_wr(wr), .mem_rd(rd),
    .mem_bank(), .mem_row(), .mem_col(col), .mem_wdata(wdata), .mem_byte_en(ben),
    .mem_rdata(rdata), .mode_opcode(opcode), .bank_open(open), .power_down(pd),
    .self_refresh(), .clock_suspend(susp), .refresh_pulse(rfp), .cmd_refused(refused));
  array_model model (.ref_clk(ref_clk), .mem_wr(wr), .mem_rd(rd), .mem_col(col),
    .mem_wdata(wdata), .mem_byte_en(ben), .mem_rdata(rdata));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Command for one edge, then no-operation
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    {cs_n, ras_n, cas_n, we_n} <= c;
    bank <= b;
    addr <= a;
    @(posedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100us;
    bad_count++;
    wrap_up();
  end
  initial begin
    reset = 1'b1; {cs_n, ras_n, cas_n, we_n} = 4'h7; hold = 1'b1;
    bank = 2'h0; addr = 13'h0000; mask = 4'h0; din = 32'h0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk("opcode", 32'h0020, opcode);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      issue(rows[i].cmd, rows[i].bank, rows[i].addr);
      @(negedge ref_clk);
      chk("bank_open", rows[i].open, open);
      chk("refused", rows[i].refused, refused);
    end
    chk("opcode", 32'h0032, opcode);
    @(posedge ref_clk);
    issue(4'h1, 2'h0, 13'h0000);
    @(negedge ref_clk);
    chk("refresh", 32'h1, rfp);
    @(posedge ref_clk);
    issue(4'h3, 2'h2, 13'h0005);
    @(posedge ref_clk);
    // Burst of four from column 6, linear wrap, lane 0 masked on beat 1
    {cs_n, ras_n, cas_n, we_n} <= 4'h4; bank <= 2'h2; addr <= 13'h0006; din <= 32'ha0b0c0d0;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'h7;
      din <= 32'ha0b0c0d1 + k;
      mask <= (k == 0) ? 4'h1 : 4'h0;
      @(negedge ref_clk);
      chk("wr", 32'h1, wr);
      chk("col", 32'h4 | ((32'h2 + k) & 32'h3), col);
      chk("wdata", 32'ha0b0c0d0 + k, wdata);
      chk("byte_en", (k == 1) ? 32'he : 32'hf, ben);
    end
    @(negedge ref_clk);
    chk("wr_end", 32'h0, wr);
    @(posedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h5;
    @(posedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    mask <= 4'h8;
    @(posedge ref_clk);
    mask <= 4'h0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("oe0", 32'h7, oe);
    chk("dout0", 32'hb0c0d0, {8'h0, dout[23:0]});
    @(negedge ref_clk);
    chk("oe1", 32'hf, oe);
    @(negedge ref_clk);
    chk("dout2", 32'ha0b0c0d2, dout);
    // Hold dropped in a read burst gives one suspended cycle
    @(posedge ref_clk);
    issue(4'h5, 2'h2, 13'h0004);
    hold <= 1'b0;
    @(posedge ref_clk);
    hold <= 1'b1;
    @(negedge ref_clk);
    chk("suspend", 32'h1, susp);
    @(posedge ref_clk);
    issue(4'h2, 2'h0, 13'h0400);
    hold <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("power_down", 32'h1, pd);
    @(posedge ref_clk);
    hold <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pd_held", 32'h1, pd);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("power_up", 32'h0, pd);
    wrap_up();
  end
endmodule

`default_nettype wire
